//--- rtl/digital_io_port_sampler.sv
// Top of the 32-bit general purpose port with output launch and decimated input capture
//
// The register addresses and the plain strobed port were chosen for this implementation.
module digital_io_port_sampler #(
	parameter logic [31:0] DECIM_DEFAULT = io_port_pkg::DECIM_RESET
) (
	input  wire logic                              clock,
	input  wire logic                              rst,
	input  wire logic [io_port_pkg::ADDR_WIDTH-1:0] address,
	input  wire logic [io_port_pkg::DATA_WIDTH-1:0] write_data,
	input  wire logic                              write_strobe,
	input  wire logic                              read_strobe,
	output logic      [io_port_pkg::DATA_WIDTH-1:0] read_data,
	input  wire logic [io_port_pkg::PORT_WIDTH-1:0] sequencer_data,
	input  wire logic [io_port_pkg::PORT_WIDTH-1:0] result_data,
	input  wire logic [io_port_pkg::PORT_WIDTH-1:0] general_io_port_in,
	output logic      [io_port_pkg::PORT_WIDTH-1:0] general_io_port_out,
	output logic      [io_port_pkg::PORT_WIDTH-1:0] general_io_port_oe,
	output logic                                   sample_clock_out_pin,
	input  wire logic                              external_clock_in_pin,
	output logic                                   capture_pulse
);
	import io_port_pkg::*;

	decim_if dbus ();

	// ==========================================================
	// Input synchronisers
	logic [PORT_WIDTH-1:0] pin_meta;
	logic [PORT_WIDTH-1:0] pin_sync;
	logic                  ext_meta;
	logic                  ext_sync;
	logic                  ext_prev;

	// Two flops on every pin before any logic looks at it
	always_ff @(posedge clock) begin
		if (rst) begin
			pin_meta <= 32'h0000_0000;
			pin_sync <= 32'h0000_0000;
		end else begin
			pin_meta <= general_io_port_in;
			pin_sync <= pin_meta;
		end
	end

	// External clock pin: two flops, then a third to find its rising edge
	always_ff @(posedge clock) begin
		if (rst) begin
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
			ext_prev <= 1'b0;
		end else begin
			ext_meta <= external_clock_in_pin;
			ext_sync <= ext_meta;
			ext_prev <= ext_sync;
		end
	end

	// ==========================================================
	// Register file
	mode_t                 mode;
	clk_sel_t              clk_sel;
	logic [LANES-1:0]      drive;
	logic [PORT_WIDTH-1:0] out_value;
	logic [DATA_WIDTH-1:0] decim;
	mode_t                 next_mode;
	clk_sel_t              next_clk_sel;
	logic [LANES-1:0]      next_drive;
	logic [PORT_WIDTH-1:0] next_out_value;
	logic [DATA_WIDTH-1:0] next_decim;
	logic                  cfg_restart;
	logic                  next_cfg_restart;
	logic                  wr_ctrl;
	logic                  wr_drive;
	logic                  wr_output;
	logic                  wr_decim;
	mode_t                 write_mode;
	clk_sel_t              write_clk_sel;

	// One select per writable register
	assign wr_ctrl   = write_strobe && (address == ADDR_CTRL);
	assign wr_drive  = write_strobe && (address == ADDR_DRIVE);
	assign wr_output = write_strobe && (address == ADDR_OUTPUT);
	assign wr_decim  = write_strobe && (address == ADDR_DECIM);

	// Decode of a written control word; code 3 falls back to manual
	always_comb begin
		case (write_data[CTRL_MODE_MSB:CTRL_MODE_LSB])
			2'h1:    write_mode = mode_sequencer;
			2'h2:    write_mode = mode_result;
			default: write_mode = mode_manual;
		endcase
		write_clk_sel = write_data[CTRL_CLKSEL_BIT] ? sel_external : sel_internal;
	end

	// Software writes; a new decimation or clock source restarts the count
	always_comb begin
		next_mode        = mode;
		next_clk_sel     = clk_sel;
		next_drive       = drive;
		next_out_value   = out_value;
		next_decim       = decim;
		next_cfg_restart = wr_ctrl | wr_decim;
		if (wr_ctrl) begin
			next_mode    = write_mode;
			next_clk_sel = write_clk_sel;
		end
		if (wr_drive) begin
			next_drive = write_data[LANES-1:0];
		end
		if (wr_output) begin
			next_out_value = write_data;
		end
		if (wr_decim) begin
			next_decim = write_data;
		end
	end

	// Register file flops, decimation default applied at reset
	always_ff @(posedge clock) begin
		if (rst) begin
			mode        <= mode_t'(MODE_RESET);
			clk_sel     <= clk_sel_t'(CLKSEL_RESET);
			drive       <= DRIVE_RESET;
			out_value   <= OUTPUT_RESET;
			decim       <= DECIM_DEFAULT;
			cfg_restart <= 1'b0;
		end else begin
			mode        <= next_mode;
			clk_sel     <= next_clk_sel;
			drive       <= next_drive;
			out_value   <= next_out_value;
			decim       <= next_decim;
			cfg_restart <= next_cfg_restart;
		end
	end

	// ==========================================================
	// Internal port clock, also driven out on the connector
	logic [DIV_WIDTH-1:0] div_count;
	logic [DIV_WIDTH-1:0] next_div_count;
	logic                 int_clk;
	logic                 next_int_clk;
	logic                 int_rise;
	logic                 int_fall;

	// Divider toggles the port clock each half period
	always_comb begin
		next_div_count = div_count + 8'h01;
		next_int_clk   = int_clk;
		int_rise       = 1'b0;
		int_fall       = 1'b0;
		if (div_count == DIV_LAST) begin
			next_div_count = 8'h00;
			next_int_clk   = ~int_clk;
			int_rise       = ~int_clk;
			int_fall       = int_clk;
		end
	end

	// Divider flops; the pin follows the clock flop directly
	always_ff @(posedge clock) begin
		if (rst) begin
			div_count <= 8'h00;
			int_clk   <= 1'b0;
		end else begin
			div_count <= next_div_count;
			int_clk   <= next_int_clk;
		end
	end

	assign sample_clock_out_pin = int_clk;

	// ==========================================================
	// Output launch on the falling edge of the port clock
	logic [PORT_WIDTH-1:0] source_value;
	logic [PORT_WIDTH-1:0] lane_mask;
	logic [PORT_WIDTH-1:0] next_port_out;
	logic [PORT_WIDTH-1:0] next_port_oe;

	// Mode picks the source
	always_comb begin
		case (mode)
			mode_manual:    source_value = out_value;
			mode_sequencer: source_value = sequencer_data;
			mode_result:    source_value = result_data;
			default:        source_value = out_value;
		endcase
	end

	// One drive bit opens all eight pins of its lane, never part of one
	for (genvar lane = 0; lane < LANES; lane++) begin : g_lane
		assign lane_mask[lane*LANE_WIDTH +: LANE_WIDTH] = {LANE_WIDTH{drive[lane]}};
	end

	// Value and lane enables load together as the port clock falls
	always_comb begin
		next_port_out = general_io_port_out;
		next_port_oe  = general_io_port_oe;
		if (int_fall) begin
			next_port_out = source_value;
			next_port_oe  = lane_mask;
		end
	end

	// Output pin flops
	always_ff @(posedge clock) begin
		if (rst) begin
			general_io_port_out <= OUTPUT_RESET;
			general_io_port_oe  <= 32'h0000_0000;
		end else begin
			general_io_port_out <= next_port_out;
			general_io_port_oe  <= next_port_oe;
		end
	end

	// ==========================================================
	// Capture clock source
	logic ext_rise;
	logic sel_tick;

	// Rising edge of the synchronised external pin, or of the port clock
	assign ext_rise = ext_sync & ~ext_prev;
	assign sel_tick = (clk_sel == sel_external) ? ext_rise : int_rise;

	// ==========================================================
	// Decimated input capture
	// Decimation unit hookup
	assign dbus.tick    = sel_tick;
	assign dbus.restart = cfg_restart;
	assign dbus.limit   = decim;

	// Counts selected clock edges and strobes each capture
	io_port_decimator u_decim (
		.clock (clock),
		.rst   (rst),
		.bus   (dbus.unit)
	);

	logic [PORT_WIDTH-1:0] captured;
	logic [PORT_WIDTH-1:0] next_captured;
	logic [DATA_WIDTH-1:0] cap_count;
	logic [DATA_WIDTH-1:0] next_cap_count;
	logic                  next_capture_pulse;

	// Latch the synchronised pins on each strobe
	always_comb begin
		next_captured      = captured;
		next_cap_count     = cap_count;
		next_capture_pulse = dbus.capture;
		if (dbus.capture) begin
			next_captured  = pin_sync;
			next_cap_count = cap_count + 32'h0000_0001;
		end
	end

	// Capture flops
	always_ff @(posedge clock) begin
		if (rst) begin
			captured      <= 32'h0000_0000;
			cap_count     <= 32'h0000_0000;
			capture_pulse <= 1'b0;
		end else begin
			captured      <= next_captured;
			cap_count     <= next_cap_count;
			capture_pulse <= next_capture_pulse;
		end
	end

	// ==========================================================
	// Read data, valid the cycle after the strobe only
	logic [DATA_WIDTH-1:0] next_read_data;
	logic [DATA_WIDTH-1:0] ctrl_word;
	logic [DATA_WIDTH-1:0] drive_word;

	// Readback of the narrow registers, zero above their fields
	assign ctrl_word  = {29'h0000_0000, clk_sel, mode};
	assign drive_word = {28'h000_0000, drive};

	// Read mux, unmapped reads give zero
	always_comb begin
		next_read_data = 32'h0000_0000;
		if (read_strobe) begin
			case (address)
				ADDR_CTRL:     next_read_data = ctrl_word;
				ADDR_DRIVE:    next_read_data = drive_word;
				ADDR_OUTPUT:   next_read_data = out_value;
				ADDR_LIVE:     next_read_data = pin_sync;
				ADDR_CAPTURED: next_read_data = captured;
				ADDR_DECIM:    next_read_data = decim;
				ADDR_CAPCOUNT: next_read_data = cap_count;
				default:       next_read_data = 32'h0000_0000;
			endcase
		end
	end

	// Read data flop
	always_ff @(posedge clock) begin
		if (rst) begin
			read_data <= 32'h0000_0000;
		end else begin
			read_data <= next_read_data;
		end
	end

endmodule

//--- rtl/io_port_pkg.sv
// Constants, types and register map of the digital input/output port sampler
package io_port_pkg;

	// ==========================================================
	// Clock figures
	localparam int CLOCK_HZ         = 25_000_000;
	localparam int PORT_CLOCK_HZ    = 50_000_000;
	// Half period of the port clock in system cycles, rounded down, at least one
	localparam int PORT_HALF_RAW    = CLOCK_HZ / (2 * PORT_CLOCK_HZ);
	localparam int PORT_HALF_CYCLES = (PORT_HALF_RAW < 1) ? 1 : PORT_HALF_RAW;
	localparam int DIV_WIDTH        = 8;
	localparam logic [DIV_WIDTH-1:0] DIV_LAST = DIV_WIDTH'(PORT_HALF_CYCLES - 1);

	// ==========================================================
	// Port geometry
	localparam int PORT_WIDTH = 32;
	localparam int LANE_WIDTH = 8;
	localparam int LANES      = PORT_WIDTH / LANE_WIDTH;

	// ==========================================================
	// Register bus and map
	localparam int ADDR_WIDTH = 8;
	localparam int DATA_WIDTH = 32;
	localparam logic [ADDR_WIDTH-1:0] ADDR_CTRL     = 8'h00;
	localparam logic [ADDR_WIDTH-1:0] ADDR_DRIVE    = 8'h04;
	localparam logic [ADDR_WIDTH-1:0] ADDR_OUTPUT   = 8'h08;
	localparam logic [ADDR_WIDTH-1:0] ADDR_LIVE     = 8'h0c;
	localparam logic [ADDR_WIDTH-1:0] ADDR_CAPTURED = 8'h10;
	localparam logic [ADDR_WIDTH-1:0] ADDR_DECIM    = 8'h14;
	localparam logic [ADDR_WIDTH-1:0] ADDR_CAPCOUNT = 8'h18;

	// Control register fields
	localparam int CTRL_MODE_LSB   = 0;
	localparam int CTRL_MODE_MSB   = 1;
	localparam int CTRL_CLKSEL_BIT = 2;

	// Reset values
	localparam logic [1:0]            MODE_RESET   = 2'h0;
	localparam logic                  CLKSEL_RESET = 1'h0;
	localparam logic [LANES-1:0]      DRIVE_RESET  = 4'h0;
	localparam logic [PORT_WIDTH-1:0] OUTPUT_RESET = 32'h0000_0000;
	localparam logic [DATA_WIDTH-1:0] DECIM_RESET  = 32'h0055_d4a8;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		mode_manual,
		mode_sequencer,
		mode_result
	} mode_t;

	typedef enum logic {
		sel_internal,
		sel_external
	} clk_sel_t;

endpackage

//--- rtl/decim_if.sv
// Connection between the port top and its decimation unit
interface decim_if;
	logic        tick;      // One selected input clock edge
	logic        restart;   // Clear the count, new setting
	logic [31:0] limit;     // Clock edges per capture
	logic        capture;   // One-cycle capture strobe

	modport ctrl (output tick, output restart, output limit, input capture);
	modport unit (input tick, input restart, input limit, output capture);
endinterface

//--- rtl/io_port_decimator.sv
// Decimation unit: counts selected input clock edges and issues capture strobes
module io_port_decimator (
	input  wire logic clock,
	input  wire logic rst,
	decim_if.unit     bus
);
	import io_port_pkg::*;

	logic [31:0] count;
	logic [31:0] next_count;
	logic        capture;
	logic        next_capture;
	logic [31:0] limit_eff;

	// ==========================================================
	// Counter next state; a zero limit behaves as one
	always_comb begin
		limit_eff    = (bus.limit == 32'h0000_0000) ? 32'h0000_0001 : bus.limit;
		next_count   = count;
		next_capture = 1'b0;
		if (bus.restart) begin
			next_count = 32'h0000_0000;
		end else if (bus.tick) begin
			if ((count + 32'h0000_0001) >= limit_eff) begin
				next_capture = 1'b1;
				next_count   = 32'h0000_0000;
			end else begin
				next_count = count + 32'h0000_0001;
			end
		end
	end

	// Counter registers
	always_ff @(posedge clock) begin
		if (rst) begin
			count   <= 32'h0000_0000;
			capture <= 1'b0;
		end else begin
			count   <= next_count;
			capture <= next_capture;
		end
	end

	assign bus.capture = capture;

endmodule

//--- tb/io_port_checker.sv
// Port-level checks of the digital port sampler
module io_port_checker (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic [7:0]  address,
	input wire logic [31:0] write_data,
	input wire logic        write_strobe,
	input wire logic [31:0] general_io_port_out,
	input wire logic [31:0] general_io_port_oe,
	input wire logic        sample_clock_out_pin,
	input wire logic        capture_pulse
);
	import io_port_pkg::*;
	logic [7:0]  gap, next_gap;
	logic [31:0] dec, next_dec;
	logic        ext, next_ext, quiet, next_quiet, cfg_wr;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	// ==========================================================
	// Mirror of capture setup and spacing since the last capture
	assign cfg_wr = write_strobe && (address == ADDR_CTRL || address == ADDR_DECIM);
	always_comb begin
		next_gap = capture_pulse ? 8'h01 : ((gap == 8'hff) ? gap : gap + 8'h01);
		next_quiet = cfg_wr ? 1'b0 : (capture_pulse ? 1'b1 : quiet);
		next_dec = (write_strobe && address == ADDR_DECIM) ? write_data : dec;
		next_ext = (write_strobe && address == ADDR_CTRL) ? write_data[2] : ext;
	end
	always_ff @(posedge clock) begin
		gap <= rst ? 8'h00 : next_gap;
		quiet <= rst ? 1'b0 : next_quiet;
		dec <= rst ? DECIM_RESET : next_dec;
		ext <= rst ? 1'b0 : next_ext;
	end

	// ==========================================================
	// Assertions
	a_clk_toggles: assert property (!$past(rst) |-> sample_clock_out_pin != $past(sample_clock_out_pin))
		else $error("sample clock did not toggle");
	a_out_on_fall: assert property ($changed(general_io_port_out) |-> $fell(sample_clock_out_pin))
		else $error("output changed off the clock fall");
	a_oe_on_fall: assert property ($changed(general_io_port_oe) |-> $fell(sample_clock_out_pin))
		else $error("enable changed off the clock fall");
	a_lane_groups: assert property (general_io_port_oe == {{8{general_io_port_oe[31]}},
		{8{general_io_port_oe[23]}}, {8{general_io_port_oe[15]}}, {8{general_io_port_oe[7]}}})
		else $error("enable split inside a lane");
	a_oe_reset: assert property ($past(rst) |-> general_io_port_oe == 32'h0)
		else $error("lanes driven after reset");
	a_pulse_single: assert property (capture_pulse |=> !capture_pulse)
		else $error("capture pulse too long");
	a_no_early_cap: assert property ($fell(rst) |-> !capture_pulse [*8])
		else $error("capture too soon after reset");
	a_cap_period: assert property (capture_pulse && quiet && !ext && dec == 32'h2 |-> gap == 8'h04)
		else $error("internal capture spacing wrong");

	c_cap_int: cover property (capture_pulse && quiet && !ext);
	c_cap_ext: cover property (capture_pulse && ext);
	c_drive_on: cover property ($rose(general_io_port_oe[0]));
endmodule

//--- tb/far_side_equipment.sv
// Model of the equipment on the port connector
module far_side_equipment (
	input  wire logic        ext_run,
	input  wire logic [31:0] pattern,
	input  wire logic [31:0] pin_out,
	input  wire logic [31:0] pin_oe,
	output logic      [31:0] pin_level,
	output logic             ext_clock
);
	timeunit 1ns;
	timeprecision 100ps;

	// Undriven lanes carry the equipment's own value
	assign pin_level = (pin_out & pin_oe) | (pattern & ~pin_oe);

	// External capture clock, still between frames
	initial begin
		ext_clock = 1'b0;
		forever begin
			@(posedge ext_run);
			#7;
			while (ext_run) begin
				#160 ext_clock = 1'b1;
				#160 ext_clock = 1'b0;
			end
		end
	end
endmodule

//--- tb/testbench.sv
// Self-checking testbench of the digital port sampler
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import io_port_pkg::*;
	logic        clock, rst, write_strobe, read_strobe, capture_pulse, clk_out, ext_pin, ext_run;
	logic [7:0]  address;
	logic [31:0] write_data, read_data, seq_data, res_data, port_in, port_out, port_oe, pattern;
	int          fail_count = 0;
	int          checks = 0;
	int          pulses = 0;

	digital_io_port_sampler dut_u (.clock(clock), .rst(rst), .address(address),
		.write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
		.read_data(read_data), .sequencer_data(seq_data), .result_data(res_data),
		.general_io_port_in(port_in), .general_io_port_out(port_out),
		.general_io_port_oe(port_oe), .sample_clock_out_pin(clk_out),
		.external_clock_in_pin(ext_pin), .capture_pulse(capture_pulse));
	far_side_equipment far_u (.ext_run(ext_run), .pattern(pattern), .pin_out(port_out),
		.pin_oe(port_oe), .pin_level(port_in), .ext_clock(ext_pin));

	// ==========================================================
	// Shared tasks
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		write_strobe <= 1'b1;
		address <= a;
		write_data <= d;
		@(posedge clock);
		write_strobe <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
		@(posedge clock);
		read_strobe <= 1'b1;
		address <= a;
		@(posedge clock);
		read_strobe <= 1'b0;
		#1;
		check(name, read_data, exp);
	endtask
	task automatic settle();
		repeat (4) @(posedge clock);
		#1;
	endtask
	task automatic wait_pulse(output int n);
		n = 0;
		do begin
			@(posedge clock);
			#1;
			n++;
			if (n > 600) begin
				check("capture wait", 32'h0, 32'h1);
				end_sim();
			end
		end while (capture_pulse !== 1'b1);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		logic prev;
		rd(ADDR_DECIM, 32'd5625000, "decim reset");
		rd(ADDR_CTRL, 32'h0, "ctrl reset");
		rd(8'hfc, 32'h0, "unmapped read");
		check("oe reset", port_oe, 32'h0);
		prev = clk_out;
		@(posedge clock);
		#1;
		check("clock out toggles", {31'h0, clk_out}, {31'h0, ~prev});
	endtask
	task automatic t_manual();
		wr(ADDR_OUTPUT, 32'ha5c3_3c5a);
		wr(ADDR_DRIVE, 32'h5);
		settle();
		check("oe lanes 0 2", port_oe, 32'h00ff_00ff);
		check("out lanes 0 2", port_out & port_oe, 32'h00c3_005a);
		rd(ADDR_LIVE, 32'h12c3_565a, "pins mixed");
		rd(ADDR_OUTPUT, 32'ha5c3_3c5a, "output readback");
		rd(ADDR_DRIVE, 32'h5, "drive readback");
		wr(ADDR_DRIVE, 32'ha);
		settle();
		check("oe lanes 1 3", port_oe, 32'hff00_ff00);
		check("out lanes 1 3", port_out & port_oe, 32'ha500_3c00);
	endtask
	task automatic t_modes();
		logic [31:0] exp [4] = '{32'ha5c3_3c5a, 32'h0f0f_0f0f, 32'hf0f0_f0f0, 32'ha5c3_3c5a};
		wr(ADDR_DRIVE, 32'hf);
		for (int m = 0; m < 4; m++) begin
			wr(ADDR_CTRL, 32'(m));
			settle();
			check("mode output", port_out, exp[m]);
		end
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_DRIVE, 32'h0);
	endtask
	task automatic t_cap_int();
		int n;
		pattern <= 32'h9abc_def0;
		wr(ADDR_DECIM, 32'h2);
		wait_pulse(n);
		wait_pulse(n);
		check("internal spacing", 32'(n), 32'd4);
		rd(ADDR_CAPTURED, 32'h9abc_def0, "captured pins");
	endtask
	task automatic t_cap_ext();
		int n;
		pattern <= 32'h0bad_f00d;
		wr(ADDR_CTRL, 32'h4);
		ext_run <= 1'b1;
		wait_pulse(n);
		wait_pulse(n);
		check("external spacing", 32'(n >= 15 && n <= 17), 32'h1);
		rd(ADDR_CAPTURED, 32'h0bad_f00d, "captured external");
		ext_run <= 1'b0;
		n = 0;
		repeat (40) begin
			@(posedge clock);
			#1;
			n += int'(capture_pulse === 1'b1);
		end
		check("still clock captures", 32'(n), 32'h0);
		rd(ADDR_CAPCOUNT, 32'(pulses), "capture count");
	endtask

	// ==========================================================
	// Clock and main sequence
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// Pulses seen on the capture output, held against the count register
	always @(posedge clock) begin
		if (capture_pulse === 1'b1) begin
			pulses <= pulses + 1;
		end
	end
	initial begin
		rst = 1'b1;
		{write_strobe, read_strobe, ext_run} = 3'h0;
		address = 8'h00;
		write_data = 32'h0;
		seq_data = 32'h0f0f_0f0f;
		res_data = 32'hf0f0_f0f0;
		pattern = 32'h1234_5678;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		t_reset();
		t_manual();
		t_modes();
		t_cap_int();
		t_cap_ext();
		end_sim();
	end
endmodule

bind digital_io_port_sampler io_port_checker chk_u (.clock(clock), .rst(rst),
	.address(address), .write_data(write_data), .write_strobe(write_strobe),
	.general_io_port_out(general_io_port_out), .general_io_port_oe(general_io_port_oe),
	.sample_clock_out_pin(sample_clock_out_pin), .capture_pulse(capture_pulse));
